// file: rtl/tmcc_timer.sv
// 16-bit up-counter with two capture/compare registers and pulse output.
// Assumes pins and control bits are synchronous to clk_i (the count clock).
//
// Contract
// - Mode 01 counts up every count clock.
// - After FFFFH set overflow, wrap, keep counting.
// - Compare A match raises first interrupt, no clear.
// - Compare B match raises second interrupt, no clear.
// - Capture A source selectable between both triggers.
// - Capture B uses only first trigger input.
// - Second trigger edge use disables output pin.
// - Both compare: toggle output on either match.
// - Capture B on trigger A edge, second interrupt.
// - Both capture: toggle only on edge if enabled.
// - Only second trigger enabled: no capture into B.
// - Mode 11 restarts on A match, B sets width.
// - Period A plus one, duty B+1 over A+1.
// - Counter reads current count while running.
// - Two-bit edge select per trigger input.
// - Reverse-phase capture into A without first interrupt.
`timescale 1ns/10ps
`default_nettype none
`include "tmcc_defs.svh"

module tmcc_timer
#(
   parameter int CNT_W = 16
)
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire tmcc_pkg::tmcc_mode_t op_mode_i,
   input wire logic cc_a_capture_i,
   input wire logic cc_b_capture_i,
   input wire logic reverse_phase_capture_sel_i,
   input wire logic output_toggle_on_edge_i,
   input wire tmcc_pkg::tmcc_edge_t edge_sel_a_i,
   input wire tmcc_pkg::tmcc_edge_t edge_sel_b_i,
   input wire logic trigger_in_a_i,
   input wire logic trigger_in_b_i,
   input wire logic reg_a_wr_i,
   input wire logic reg_b_wr_i,
   input wire logic [CNT_W-1:0] wr_data_i,
   input wire logic overflow_clear_i,
   output logic [CNT_W-1:0] up_counter_o,
   output logic [CNT_W-1:0] cycle_capture_reg_a_o,
   output logic [CNT_W-1:0] width_capture_reg_b_o,
   output logic overflow_flag_o,
   output logic irq_match_a_o,
   output logic irq_match_b_o,
   output logic timer_out_pin_o
);
   import tmcc_pkg::*;

   logic [CNT_W-1:0] up_counter;
   logic edge_a;
   logic rev_a;
   logic edge_b;
   logic running;
   logic match_a;
   logic match_b;
   logic cap_a;
   logic cap_b;
   logic pin_blocked;
   logic toggle;

   // ========================================================================
   // Trigger edge detection
   tmcc_edge_det u_edge_a
   (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .sig_i(trigger_in_a_i),
      .edge_sel_i(edge_sel_a_i),
      .valid_o(edge_a),
      .reverse_o(rev_a)
   );

   tmcc_edge_det u_edge_b
   (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .sig_i(trigger_in_b_i),
      .edge_sel_i(edge_sel_b_i),
      .valid_o(edge_b),
      .reverse_o()
   );

   // ========================================================================
   // Event decode
   assign running = (op_mode_i != TMCC_STOP);
   assign match_a = running && !cc_a_capture_i
      && (up_counter == cycle_capture_reg_a_o);
   assign match_b = running && !cc_b_capture_i
      && (up_counter == width_capture_reg_b_o);
   assign cap_a = running && cc_a_capture_i
      && (reverse_phase_capture_sel_i ? rev_a : edge_b);
   assign cap_b = running && cc_b_capture_i && edge_a;
   // The pin doubles as the second trigger, so any edge use there owns it.
   assign pin_blocked = (edge_sel_b_i != TMCC_NONE);
   assign toggle = match_a || match_b
      || (output_toggle_on_edge_i && edge_a);

   // ========================================================================
   // Counter
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         up_counter <= `TMCC_COUNT_ZERO;
      else if (op_mode_i == TMCC_PPG && match_a)
         up_counter <= `TMCC_COUNT_ZERO;
      else if (op_mode_i == TMCC_TRIG_CLEAR && edge_a)
         up_counter <= `TMCC_COUNT_ZERO;
      else if (running)
         up_counter <= up_counter + 1'b1;
   end

   assign up_counter_o = up_counter;

   // ========================================================================
   // Overflow flag; a wrap in the clearing cycle wins over the clear.
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         overflow_flag_o <= 1'b0;
      else if ((op_mode_i == TMCC_FREE) && (up_counter == `TMCC_COUNT_MAX))
         overflow_flag_o <= 1'b1;
      else if (overflow_clear_i)
         overflow_flag_o <= 1'b0;
   end

   // ========================================================================
   // Capture/compare registers; a capture beats a software write.
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         cycle_capture_reg_a_o <= `TMCC_REG_RESET;
      else if (cap_a)
         cycle_capture_reg_a_o <= up_counter;
      else if (reg_a_wr_i)
         cycle_capture_reg_a_o <= wr_data_i;
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         width_capture_reg_b_o <= `TMCC_REG_RESET;
      else if (cap_b)
         width_capture_reg_b_o <= up_counter;
      else if (reg_b_wr_i)
         width_capture_reg_b_o <= wr_data_i;
   end

   // ========================================================================
   // Interrupt requests, one-cycle pulses
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         irq_match_a_o <= 1'b0;
         irq_match_b_o <= 1'b0;
      end
      else
      begin
         // Reverse-phase capture alone stays silent on the first request.
         irq_match_a_o <= match_a
            || (running && cc_a_capture_i && edge_b);
         irq_match_b_o <= match_b || cap_b;
      end
   end

   // ========================================================================
   // Timer output
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         timer_out_pin_o <= 1'b0;
      else if (pin_blocked)
         timer_out_pin_o <= 1'b0;
      else if (op_mode_i == TMCC_PPG)
      begin
         // High for counts 0 to B, that is B+1 of the A+1 clocks.
         if (match_a)
            timer_out_pin_o <= 1'b1;
         else if (match_b)
            timer_out_pin_o <= 1'b0;
      end
      else if (running && toggle)
         timer_out_pin_o <= ~timer_out_pin_o;
   end

   // ========================================================================
   // Checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);

   a_free_count_step: assert property (
      (op_mode_i == TMCC_FREE) |=> (up_counter == $past(up_counter) + 1'b1))
      else $error("free-running count did not step by one");
   a_overflow_wrap: assert property (
      (op_mode_i == TMCC_FREE) && (up_counter == `TMCC_COUNT_MAX)
      |=> (up_counter == `TMCC_COUNT_ZERO) && overflow_flag_o)
      else $error("overflow did not wrap and flag");
   a_overflow_sticky: assert property (
      overflow_flag_o && !overflow_clear_i |=> overflow_flag_o [*1])
      else $error("overflow flag dropped without clear");
   a_match_a_irq: assert property (
      running && !cc_a_capture_i && (up_counter == cycle_capture_reg_a_o)
      && (op_mode_i != TMCC_PPG) && !(op_mode_i == TMCC_TRIG_CLEAR && edge_a)
      |=> irq_match_a_o && (up_counter == $past(up_counter) + 1'b1))
      else $error("compare A match missed or counter cleared");
   a_match_b_irq: assert property (
      running && !cc_b_capture_i && (up_counter == width_capture_reg_b_o)
      |=> irq_match_b_o)
      else $error("compare B match missed");
   a_capture_b_load: assert property (
      running && cc_b_capture_i && edge_a
      |=> (width_capture_reg_b_o == $past(up_counter)) && irq_match_b_o)
      else $error("capture into B failed");
   a_capture_a_src: assert property (
      running && cc_a_capture_i && !reverse_phase_capture_sel_i && edge_b
      |=> (cycle_capture_reg_a_o == $past(up_counter)) && irq_match_a_o)
      else $error("capture into A failed");
   a_reverse_quiet: assert property (
      running && cc_a_capture_i && reverse_phase_capture_sel_i && rev_a
      && !edge_b |=> !irq_match_a_o)
      else $error("reverse capture raised first request");
   a_pin_blocked: assert property (
      pin_blocked |=> !timer_out_pin_o)
      else $error("output driven while second trigger in use");
   a_ppg_restart: assert property (
      (op_mode_i == TMCC_PPG) && (up_counter == cycle_capture_reg_a_o)
      && !cc_a_capture_i |=> (up_counter == `TMCC_COUNT_ZERO)
      ##1 (up_counter == 16'h0001 || op_mode_i != TMCC_PPG || $past(match_a)))
      else $error("pulse mode did not restart");
   a_ppg_rise: assert property (
      (op_mode_i == TMCC_PPG) && match_a && !pin_blocked |=> timer_out_pin_o)
      else $error("pulse output not high at period start");
   a_capture_hold: assert property (
      (op_mode_i == TMCC_FREE) && cc_a_capture_i && cc_b_capture_i
      && !output_toggle_on_edge_i && !pin_blocked
      |=> $stable(timer_out_pin_o))
      else $error("output toggled with both registers capturing");

   c_free_wrap: cover property (
      (op_mode_i == TMCC_FREE) && (up_counter == `TMCC_COUNT_MAX));
   c_ppg_period: cover property (
      (op_mode_i == TMCC_PPG) && match_a ##[1:40] match_b);
   c_capture_both: cover property (cap_b ##[1:20] cap_a);
   c_edge_toggle: cover property (output_toggle_on_edge_i && edge_a);

endmodule : tmcc_timer

`default_nettype wire

// file: rtl/tmcc_defs.svh
// Constants for the 16-bit capture/compare timer with pulse output.
// Included by the package and the timer module; holds definitions only.
`ifndef TMCC_DEFS_SVH
`define TMCC_DEFS_SVH

// ==========================================================================
// Operating mode codes
`define TMCC_MODE_STOP 2'h0
`define TMCC_MODE_FREE 2'h1
`define TMCC_MODE_TRIG_CLEAR 2'h2
`define TMCC_MODE_PPG 2'h3

// ==========================================================================
// Valid edge codes, one two-bit field per trigger input
`define TMCC_EDGE_FALL 2'h0
`define TMCC_EDGE_RISE 2'h1
`define TMCC_EDGE_NONE 2'h2
`define TMCC_EDGE_BOTH 2'h3

// ==========================================================================
// Reset values and counter limits
`define TMCC_COUNT_MAX 16'hFFFF
`define TMCC_COUNT_ZERO 16'h0000
`define TMCC_REG_RESET 16'h0000

`endif

// file: rtl/tmcc_pkg.sv
// Types shared by the timer modules.
// Relies on tmcc_defs.svh for the encodings.
`include "tmcc_defs.svh"

package tmcc_pkg;

   // =======================================================================
   // Mode and edge selections
   typedef enum logic [1:0] {
      TMCC_STOP = `TMCC_MODE_STOP,
      TMCC_FREE = `TMCC_MODE_FREE,
      TMCC_PPG = `TMCC_MODE_PPG,
      TMCC_TRIG_CLEAR = `TMCC_MODE_TRIG_CLEAR
   } tmcc_mode_t;

   typedef enum logic [1:0] {
      TMCC_FALL = `TMCC_EDGE_FALL,
      TMCC_RISE = `TMCC_EDGE_RISE,
      TMCC_NONE = `TMCC_EDGE_NONE,
      TMCC_BOTH = `TMCC_EDGE_BOTH
   } tmcc_edge_t;

endpackage : tmcc_pkg

// file: rtl/tmcc_edge_det.sv
// Valid-edge detector for one trigger input.
// Assumes the input is already synchronous to clk_i.
`timescale 1ns/10ps
`default_nettype none

module tmcc_edge_det
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic sig_i,
   input wire tmcc_pkg::tmcc_edge_t edge_sel_i,
   output logic valid_o,
   output logic reverse_o
);
   import tmcc_pkg::*;

   logic prev;
   logic rise;
   logic fall;

   // ========================================================================
   // Previous level
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         prev <= 1'b0;
      else
         prev <= sig_i;
   end

   assign rise = sig_i & ~prev;
   assign fall = ~sig_i & prev;

   // ========================================================================
   // Valid and reverse-phase edges
   // Both-edge selection has no opposite edge, so reverse stays quiet.
   always_comb
   begin
      case (edge_sel_i)
         TMCC_FALL:
         begin
            valid_o = fall;
            reverse_o = rise;
         end
         TMCC_RISE:
         begin
            valid_o = rise;
            reverse_o = fall;
         end
         TMCC_BOTH:
         begin
            valid_o = rise | fall;
            reverse_o = 1'b0;
         end
         default:
         begin
            valid_o = 1'b0;
            reverse_o = 1'b0;
         end
      endcase
   end

endmodule : tmcc_edge_det

`default_nettype wire

// file: tb/tmcc_pulse_env.sv
// Pulse sources that drive the two trigger pins of the timer.
// Assumes the bench calls drive from one process, once per clock edge.
`timescale 1ns/10ps
`default_nettype none

module tmcc_pulse_env
(
   input wire logic clk_i,
   output logic trigger_in_a_o,
   output logic trigger_in_b_o
);
   // ==========
   // Pin drivers
   // Pins start low so that the release of reset shows no false edge.
   initial
   begin
      trigger_in_a_o = 1'b0;
      trigger_in_b_o = 1'b0;
   end

   // Both pins move on one edge, so a single call can reach both detectors.
   task drive(input logic a, input logic b);
      @(posedge clk_i);
      trigger_in_a_o <= a;
      trigger_in_b_o <= b;
   endtask : drive
endmodule : tmcc_pulse_env
`default_nettype wire

// file: tb/timer16_capture_compare_ppg_tb.sv
// Self-checking bench for the capture/compare timer with pulse output.
// Assumes the package and the design files are compiled first.
`timescale 1ns/10ps
`default_nettype none

module timer16_capture_compare_ppg_tb;
   import tmcc_pkg::*;
   logic clk_i = 1'b0, resetn_i = 1'b0, cc_a_capture_i = 1'b0;
   logic cc_b_capture_i = 1'b0, reverse_phase_capture_sel_i = 1'b0;
   logic output_toggle_on_edge_i = 1'b0, reg_a_wr_i = 1'b0;
   logic reg_b_wr_i = 1'b0, overflow_clear_i = 1'b0;
   logic trigger_in_a_i, trigger_in_b_i, overflow_flag_o, o;
   logic irq_match_a_o, irq_match_b_o, timer_out_pin_o;
   logic [15:0] wr_data_i = 16'h0000, up_counter_o, m, n, cnt, hi;
   logic [15:0] cycle_capture_reg_a_o, width_capture_reg_b_o;
   tmcc_mode_t op_mode_i = TMCC_STOP;
   tmcc_edge_t edge_sel_a_i = TMCC_NONE, edge_sel_b_i = TMCC_NONE;
   int fail_count = 0, n_checks = 0, cycles = 0, i;

   tmcc_timer DUT
   (
      .clk_i, .resetn_i, .op_mode_i, .cc_a_capture_i, .cc_b_capture_i,
      .reverse_phase_capture_sel_i, .output_toggle_on_edge_i,
      .edge_sel_a_i, .edge_sel_b_i, .trigger_in_a_i, .trigger_in_b_i,
      .reg_a_wr_i, .reg_b_wr_i, .wr_data_i, .overflow_clear_i,
      .up_counter_o, .cycle_capture_reg_a_o, .width_capture_reg_b_o,
      .overflow_flag_o, .irq_match_a_o, .irq_match_b_o, .timer_out_pin_o
   );
   tmcc_pulse_env env
   (
      .clk_i,
      .trigger_in_a_o(trigger_in_a_i),
      .trigger_in_b_o(trigger_in_b_i)
   );

   // ==========
   // Checks and bus tasks
   task final_report();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : final_report

   task chk_val(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk_val

   task chk_bit(input logic got, input logic exp);
      chk_val({15'h0000, got}, {15'h0000, exp});
   endtask : chk_bit

   task wr(input logic b, input logic [15:0] v);
      @(posedge clk_i);
      reg_a_wr_i <= ~b;
      reg_b_wr_i <= b;
      wr_data_i <= v;
      @(posedge clk_i);
      reg_a_wr_i <= 1'b0;
      reg_b_wr_i <= 1'b0;
   endtask : wr

   // Bounded so that a stuck counter ends in a mismatch, not a hang.
   task wait_cnt(input logic [15:0] v);
      int k;
      k = 0;
      while (up_counter_o !== v && k < 70000)
      begin
         @(posedge clk_i);
         #1;
         k++;
      end
      if (k >= 70000)
      begin
         fail_count++;
         $display("[FAIL] %0t counter never reached %h", $time, v);
      end
   endtask : wait_cnt

   // Next free-running count, wrapping at the top of the 16-bit range.
   function automatic logic [15:0] exp_next(input logic [15:0] c);
      return c + 16'h0001;
   endfunction : exp_next

   task match_chk(input logic [15:0] v, input logic second);
      wait_cnt(v);
      o = timer_out_pin_o;
      @(posedge clk_i);
      #1;
      chk_bit(second ? irq_match_b_o : irq_match_a_o, 1'b1);
      chk_bit(timer_out_pin_o, ~o);
      chk_val(up_counter_o, exp_next(v));
   endtask : match_chk

   task end_test(input string s);
      $display("test done: %s", s);
   endtask : end_test

   // ==========
   // Clock and watchdog
   initial
   begin
      forever #20 clk_i = ~clk_i;
   end

   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 90000)
      begin
         fail_count++;
         $display("[FAIL] %0t run did not finish", $time);
         final_report();
      end
   end

   // ==========
   // Scenarios
   initial
   begin
      void'($urandom(21));
      repeat (8) @(posedge clk_i);
      resetn_i <= 1'b1;
      m = 16'h0008 + 16'($urandom % 24);
      n = 16'($urandom % m);
      wr(1'b0, m);
      wr(1'b1, n);
      @(posedge clk_i);
      op_mode_i <= TMCC_PPG;
      #1;
      wait_cnt(m);
      @(posedge clk_i);
      #1;
      chk_val(up_counter_o, 16'h0000);
      chk_bit(timer_out_pin_o, 1'b1);
      hi = 16'h0000;
      repeat (m + 1)
      begin
         hi = hi + {15'h0000, timer_out_pin_o};
         @(posedge clk_i);
         #1;
      end
      chk_val(hi, exp_next(n));
      chk_val(up_counter_o, 16'h0000);
      end_test("pulse generator");
      @(posedge clk_i);
      op_mode_i <= TMCC_FREE;
      repeat (2) @(posedge clk_i);
      #1;
      repeat (16)
      begin
         cnt = up_counter_o;
         @(posedge clk_i);
         #1;
         chk_val(up_counter_o, exp_next(cnt));
      end
      chk_bit(overflow_flag_o, 1'b0);
      m = 16'h0100 + 16'($urandom % 256);
      n = m + 16'h0010 + 16'($urandom % 16);
      wr(1'b0, m);
      wr(1'b1, n);
      #1;
      match_chk(m, 1'b0);
      match_chk(n, 1'b1);
      end_test("compare");
      wait_cnt(16'hFFFF);
      @(posedge clk_i);
      #1;
      chk_val(up_counter_o, 16'h0000);
      chk_bit(overflow_flag_o, 1'b1);
      repeat (4) @(posedge clk_i);
      #1;
      chk_bit(overflow_flag_o, 1'b1);
      @(posedge clk_i);
      overflow_clear_i <= 1'b1;
      @(posedge clk_i);
      overflow_clear_i <= 1'b0;
      #1;
      chk_bit(overflow_flag_o, 1'b0);
      end_test("overflow");
      @(posedge clk_i);
      cc_a_capture_i <= 1'b1;
      cc_b_capture_i <= 1'b1;
      output_toggle_on_edge_i <= 1'b1;
      edge_sel_a_i <= TMCC_RISE;
      env.drive(1'b1, 1'b0);
      #1;
      cnt = up_counter_o;
      o = timer_out_pin_o;
      @(posedge clk_i);
      #1;
      chk_val(width_capture_reg_b_o, cnt);
      chk_bit(irq_match_b_o, 1'b1);
      chk_bit(timer_out_pin_o, ~o);
      o = timer_out_pin_o;
      env.drive(1'b0, 1'b0);
      #1;
      cnt = width_capture_reg_b_o;
      @(posedge clk_i);
      #1;
      chk_val(width_capture_reg_b_o, cnt);
      chk_bit(timer_out_pin_o, o);
      @(posedge clk_i);
      reverse_phase_capture_sel_i <= 1'b1;
      env.drive(1'b1, 1'b0);
      env.drive(1'b0, 1'b0);
      #1;
      cnt = up_counter_o;
      @(posedge clk_i);
      #1;
      chk_val(cycle_capture_reg_a_o, cnt);
      chk_bit(irq_match_a_o, 1'b0);
      @(posedge clk_i);
      reverse_phase_capture_sel_i <= 1'b0;
      output_toggle_on_edge_i <= 1'b0;
      env.drive(1'b1, 1'b0);
      #1;
      o = timer_out_pin_o;
      cnt = up_counter_o;
      @(posedge clk_i);
      #1;
      chk_val(width_capture_reg_b_o, cnt);
      chk_bit(timer_out_pin_o, o);
      @(posedge clk_i);
      edge_sel_a_i <= TMCC_NONE;
      edge_sel_b_i <= TMCC_BOTH;
      for (i = 0; i < 2; i++)
      begin
         env.drive(i == 0, i == 0);
         #1;
         cnt = up_counter_o;
         hi = width_capture_reg_b_o;
         @(posedge clk_i);
         #1;
         chk_val(cycle_capture_reg_a_o, cnt);
         chk_bit(irq_match_a_o, 1'b1);
         chk_val(width_capture_reg_b_o, hi);
         chk_bit(timer_out_pin_o, 1'b0);
      end
      end_test("capture");
      @(posedge clk_i);
      op_mode_i <= TMCC_TRIG_CLEAR;
      edge_sel_a_i <= TMCC_RISE;
      env.drive(1'b1, 1'b0);
      #1;
      cnt = up_counter_o;
      @(posedge clk_i);
      #1;
      chk_val(width_capture_reg_b_o, cnt);
      chk_val(up_counter_o, 16'h0000);
      end_test("clear on trigger");
      final_report();
   end
endmodule : timer16_capture_compare_ppg_tb
`default_nettype wire
